// ### hdl/plf_top.sv
// four-channel lock flag, reference select and output format control
// assumes lock, clock and select levels arrive asynchronously from pins or analog
`timescale 1ns/1ps
`include "plf_defines.svh"
module plf_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial register port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // per channel analog and pin inputs, plus the one shared reference oscillator
  input wire logic [3:0] pll_locked,
  input wire logic [3:0] ref_select_in,
  input wire logic [3:0] input_clock_one,
  input wire logic reference_oscillator,
  input wire logic [3:0] pll_clk,
  // lock flag pins and status
  output logic [3:0] loss_of_lock_out,
  output logic [3:0] loss_of_lock_oe,
  output logic [3:0] lock_status_bit,
  // selected source and output clock pins
  output logic [3:0] src_clk,
  output logic [3:0] output_clock_pos,
  output logic [3:0] output_clock_neg,
  output logic [3:0] output_clock_oe
);
  typedef struct packed {
    plf_pkg::plf_chan_cfg_t [3:0] cfg;
    logic [3:0] lock1, lock2;
    logic [3:0] sel1, sel2;
    logic [3:0] in1, in2;
    logic osc1, osc2;
    logic [3:0] pclk1, pclk2;
    logic [3:0] lol, lol_oe, status, src, ckp, ckn, ckoe;
    logic [2:0] warm;
  } plf_top_state_t;

  plf_top_state_t s_r, s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n_s;
  logic [7:0] rdata, ptr, waddr, wdata;
  logic wr_stb, i2c_oe;

  // reset released through two flops, asserted at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  plf_i2c_target u_i2c (
    .clk(clk),
    .rst_n(rst_n_s),
    .scl_in(scl),
    .sda_in(sda_in),
    .sda_oe(i2c_oe),
    .rdata(rdata),
    .ptr(ptr),
    .wr_stb(wr_stb),
    .waddr(waddr),
    .wdata(wdata)
  );

  // read mux; unmapped pointers read zero
  always_comb begin
    rdata = 8'h00;
    if (ptr < `PLF_REG_STATUS) begin
      rdata[`PLF_BIT_LOL_EN] = s_r.cfg[ptr[1:0]].lock_flag_pin_enable;
      rdata[`PLF_BIT_LOL_POL] = s_r.cfg[ptr[1:0]].lock_flag_polarity;
      rdata[`PLF_FMT_MSB:`PLF_FMT_LSB] = s_r.cfg[ptr[1:0]].output_format_select;
    end else if (ptr == `PLF_REG_STATUS) begin
      rdata = {4'h0, s_r.status}; // R4
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.lock1 = pll_locked;
    s_nxt.lock2 = s_r.lock1;
    s_nxt.sel1 = ref_select_in;
    s_nxt.sel2 = s_r.sel1;
    s_nxt.in1 = input_clock_one;
    s_nxt.in2 = s_r.in1;
    s_nxt.osc1 = reference_oscillator;
    s_nxt.osc2 = s_r.osc1;
    s_nxt.pclk1 = pll_clk;
    s_nxt.pclk2 = s_r.pclk1;
    // pipeline still holds reset values until this saturates
    s_nxt.warm = (s_r.warm == 3'h4) ? s_r.warm : s_r.warm + 3'h1;
    // only the addressed channel's byte changes
    if (wr_stb && waddr < `PLF_REG_STATUS) begin
      s_nxt.cfg[waddr[1:0]].lock_flag_pin_enable = wdata[`PLF_BIT_LOL_EN]; // R10
      s_nxt.cfg[waddr[1:0]].lock_flag_polarity = wdata[`PLF_BIT_LOL_POL];
      s_nxt.cfg[waddr[1:0]].output_format_select =
        plf_pkg::plf_fmt_t'(wdata[`PLF_FMT_MSB:`PLF_FMT_LSB]);
    end
    for (int i = 0; i < `PLF_CHANNELS; i++) begin
      // polarity 1 flags unlock high, 0 flags it low
      s_nxt.lol[i] = s_r.lock2[i] ^ s_r.cfg[i].lock_flag_polarity; // R1 R3
      s_nxt.lol_oe[i] = s_r.cfg[i].lock_flag_pin_enable; // R1 R2
      s_nxt.status[i] = s_r.lock2[i]; // R4
      s_nxt.src[i] = s_r.sel2[i] ? s_r.osc2 : s_r.in2[i]; // R5 R6
      unique case (s_r.cfg[i].output_format_select)
        plf_pkg::PLF_FMT_CMOS: begin
          s_nxt.ckp[i] = s_r.pclk2[i]; // R7
          s_nxt.ckn[i] = s_r.pclk2[i];
          s_nxt.ckoe[i] = 1'b1;
        end
        plf_pkg::PLF_FMT_LVPECL, plf_pkg::PLF_FMT_LVDS, plf_pkg::PLF_FMT_CML: begin
          s_nxt.ckp[i] = s_r.pclk2[i]; // R7
          s_nxt.ckn[i] = ~s_r.pclk2[i];
          s_nxt.ckoe[i] = 1'b1;
        end
        default: begin
          // off and the three unused codes keep the pair undriven
          s_nxt.ckp[i] = 1'b0;
          s_nxt.ckn[i] = 1'b0;
          s_nxt.ckoe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_r <= '0; // R9
      for (int i = 0; i < `PLF_CHANNELS; i++) begin
        s_r.cfg[i].lock_flag_pin_enable <= `PLF_RST_LOL_EN;
        s_r.cfg[i].lock_flag_polarity <= `PLF_RST_LOL_POL;
        s_r.cfg[i].output_format_select <= plf_pkg::PLF_FMT_OFF; // R9
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = i2c_oe; // R8
  assign loss_of_lock_out = s_r.lol;
  assign loss_of_lock_oe = s_r.lol_oe;
  assign lock_status_bit = s_r.status;
  assign src_clk = s_r.src;
  assign output_clock_pos = s_r.ckp;
  assign output_clock_neg = s_r.ckn;
  assign output_clock_oe = s_r.ckoe;

  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  logic [3:0] en_v, pol_v, cmos_v;
  always_comb begin
    for (int i = 0; i < `PLF_CHANNELS; i++) begin
      en_v[i] = s_r.cfg[i].lock_flag_pin_enable;
      pol_v[i] = s_r.cfg[i].lock_flag_polarity;
      cmos_v[i] = s_r.cfg[i].output_format_select == plf_pkg::PLF_FMT_CMOS;
    end
  end

  a_lock_flag_pin_enable_drive: assert property (s_r.warm == 3'h4 |->
    loss_of_lock_oe == $past(en_v)) else $error("flag pin enable mismatch"); // R1
  a_lol_tristate: assert property (
    $fell(en_v[0]) |=> !loss_of_lock_oe[0]) else $error("flag pin still driven"); // R2
  a_lol_polarity: assert property (s_r.warm == 3'h4 |->
    loss_of_lock_out == ($past(s_r.lock2) ^ $past(pol_v)))
    else $error("flag level wrong for polarity"); // R3
  a_status_mirror: assert property (s_r.warm == 3'h4 |->
    lock_status_bit == $past(pll_locked, 3)) else $error("status does not track lock"); // R4
  a_ref_select: assert property (s_r.warm == 3'h4 |->
    src_clk == (($past(ref_select_in, 3) & {4{$past(reference_oscillator, 3)}})
               | (~$past(ref_select_in, 3) & $past(input_clock_one, 3))))
    else $error("wrong clock source selected"); // R5
  a_cmos_in_phase: assert property (
    $past(cmos_v) != 4'h0 |-> ((output_clock_pos ^ output_clock_neg) & $past(cmos_v)) == 4'h0)
    else $error("cmos pair not in phase"); // R7
  a_reset_outputs_off: assert property (disable iff (1'b0)
    !rst_n_s |=> (output_clock_oe == 4'h0) [*2]) else $error("clock driven after reset"); // R9
  a_channel_isolated: assert property (
    $changed(s_r.cfg[1]) |-> $past(wr_stb) && $past(waddr) == 8'h01)
    else $error("channel changed by another's write"); // R10

  c_unlock_flag: cover property (loss_of_lock_oe[0] && loss_of_lock_out[0]);
  c_osc_selected: cover property (src_clk[2] && $past(ref_select_in[2], 3));
  c_cmos_running: cover property (output_clock_oe[3] && cmos_v[3]);
endmodule // plf_top

// ### hdl/plf_defines.svh
// constants for the four-channel lock flag and reference select block
// assumes one 40 MHz clock and an active-low asynchronous reset
//
// What this block does
// R1: with its flag enable set, a channel drives its loss-of-lock pin, by default 0 locked, 1 unlocked.
// R2: with its flag enable clear, a channel leaves its loss-of-lock pin undriven.
// R3: each channel's polarity bit sets the active level of its loss-of-lock pin.
// R4: each channel's lock state always shows in a read-only status bit, pin enabled or not.
// R5: select input low takes input clock one, high takes the reference oscillator.
// R6: the system holds every select input high or low, and high for an unused channel.
// R7: each output pair follows its format field; CMOS drives both pins alike, in phase.
// R8: registers are reached as an I2C target: clock in only, data two-way.
// R9: reset restores all register defaults and holds the clock outputs undriven until programmed.
// R10: enable, polarity, status and format are kept apart for each of the four channels.
`ifndef PLF_DEFINES_SVH
`define PLF_DEFINES_SVH

`define PLF_CHANNELS 4
`define PLF_I2C_ADDR 7'h68
// register map: one byte per channel, then status
`define PLF_REG_CH0 8'h00
`define PLF_REG_STATUS 8'h04
// channel register fields
`define PLF_BIT_LOL_EN 0
`define PLF_BIT_LOL_POL 1
`define PLF_FMT_LSB 2
`define PLF_FMT_MSB 4
// reset values: flag driven, active high, clock outputs off
`define PLF_RST_LOL_EN 1'b1
`define PLF_RST_LOL_POL 1'b1
`define PLF_BITS_PER_BYTE 4'h8

`endif

// ### hdl/plf_pkg.sv
// types shared by the lock flag block and its serial register port
// assumes plf_defines.svh is compiled alongside
package plf_pkg;

  typedef enum logic [2:0] {
    PLF_FMT_OFF,
    PLF_FMT_LVPECL,
    PLF_FMT_LVDS,
    PLF_FMT_CML,
    PLF_FMT_CMOS
  } plf_fmt_t;

  typedef struct packed {
    logic lock_flag_pin_enable;
    logic lock_flag_polarity;
    plf_fmt_t output_format_select;
  } plf_chan_cfg_t;

  typedef enum logic [2:0] {
    PLF_I2C_IDLE,
    PLF_I2C_ADDR,
    PLF_I2C_ACK_ADDR,
    PLF_I2C_REG,
    PLF_I2C_ACK,
    PLF_I2C_WRITE,
    PLF_I2C_READ,
    PLF_I2C_READ_ACK
  } plf_i2c_st_t;

  typedef struct packed {
    plf_i2c_st_t st;
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    logic [3:0] bcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wr;
    logic oe;
    logic nack;
  } plf_i2c_state_t;

endpackage

// ### hdl/plf_i2c_target.sv
// I2C target: pointer byte, then data bytes written or read, pointer auto-increments
// assumes scl and sda arrive from pins; sda is open drain, pulled high outside
`timescale 1ns/1ps
`include "plf_defines.svh"
module plf_i2c_target (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // register side
  input wire logic [7:0] rdata,
  output logic [7:0] ptr,
  output logic wr_stb,
  output logic [7:0] waddr,
  output logic [7:0] wdata
);
  plf_pkg::plf_i2c_state_t s_r, s_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;

  // edges and conditions only from the second sync stage onward
  assign scl_rise = s_r.scl2 & ~s_r.scl3;
  assign scl_fall = ~s_r.scl2 & s_r.scl3;
  assign start_c = s_r.scl2 & s_r.sda3 & ~s_r.sda2;
  assign stop_c = s_r.scl2 & ~s_r.sda3 & s_r.sda2;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl1 = scl_in;
    s_nxt.scl2 = s_r.scl1;
    s_nxt.scl3 = s_r.scl2;
    s_nxt.sda1 = sda_in;
    s_nxt.sda2 = s_r.sda1;
    s_nxt.sda3 = s_r.sda2;
    s_nxt.wr = 1'b0;
    if (start_c) begin
      s_nxt.st = plf_pkg::PLF_I2C_ADDR;
      s_nxt.bcnt = 4'h0;
      s_nxt.oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = plf_pkg::PLF_I2C_IDLE;
      s_nxt.oe = 1'b0;
    end else begin
      unique case (s_r.st)
        plf_pkg::PLF_I2C_IDLE: begin
        end
        plf_pkg::PLF_I2C_ADDR, plf_pkg::PLF_I2C_REG, plf_pkg::PLF_I2C_WRITE: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda2};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (scl_fall && s_r.bcnt == `PLF_BITS_PER_BYTE) begin
            s_nxt.oe = 1'b1; // R8
            s_nxt.bcnt = 4'h0;
            if (s_r.st == plf_pkg::PLF_I2C_ADDR) begin
              if (s_r.shreg[7:1] == `PLF_I2C_ADDR) begin
                s_nxt.st = plf_pkg::PLF_I2C_ACK_ADDR;
              end else begin
                s_nxt.st = plf_pkg::PLF_I2C_IDLE;
                s_nxt.oe = 1'b0;
              end
            end else if (s_r.st == plf_pkg::PLF_I2C_REG) begin
              s_nxt.ptr = s_r.shreg;
              s_nxt.st = plf_pkg::PLF_I2C_ACK;
            end else begin
              s_nxt.wr = 1'b1;
              s_nxt.waddr = s_r.ptr;
              s_nxt.wdata = s_r.shreg;
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.st = plf_pkg::PLF_I2C_ACK;
            end
          end
        end
        plf_pkg::PLF_I2C_ACK_ADDR: begin
          if (scl_fall) begin
            if (s_r.shreg[0]) begin
              s_nxt.shreg = rdata;
              s_nxt.oe = ~rdata[7];
              s_nxt.st = plf_pkg::PLF_I2C_READ;
            end else begin
              s_nxt.oe = 1'b0;
              s_nxt.st = plf_pkg::PLF_I2C_REG;
            end
          end
        end
        plf_pkg::PLF_I2C_ACK: begin
          if (scl_fall) begin
            s_nxt.oe = 1'b0;
            s_nxt.st = plf_pkg::PLF_I2C_WRITE;
          end
        end
        plf_pkg::PLF_I2C_READ: begin
          if (scl_fall) begin
            if (s_r.bcnt == 4'h7) begin
              s_nxt.oe = 1'b0;
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.st = plf_pkg::PLF_I2C_READ_ACK;
            end else begin
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.oe = ~s_r.shreg[6];
              s_nxt.bcnt = s_r.bcnt + 4'h1;
            end
          end
        end
        plf_pkg::PLF_I2C_READ_ACK: begin
          if (scl_rise) begin
            s_nxt.nack = s_r.sda2;
          end else if (scl_fall) begin
            s_nxt.bcnt = 4'h0;
            if (s_r.nack) begin
              s_nxt.st = plf_pkg::PLF_I2C_IDLE;
            end else begin
              s_nxt.shreg = rdata;
              s_nxt.oe = ~rdata[7];
              s_nxt.st = plf_pkg::PLF_I2C_READ;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: plf_pkg::PLF_I2C_IDLE, scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
               sda1: 1'b1, sda2: 1'b1, sda3: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe = s_r.oe;
  assign ptr = s_r.ptr;
  assign wr_stb = s_r.wr;
  assign waddr = s_r.waddr;
  assign wdata = s_r.wdata;

  a_i2c_write_ack: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb |-> sda_oe) else $error("write taken without ack driven"); // R8
  a_i2c_stop_release: assert property (@(posedge clk) disable iff (!rst_n)
    stop_c |=> !sda_oe) else $error("sda still driven after stop"); // R8
  c_i2c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_stb);
endmodule // plf_i2c_target

// ### tb/plf_sys_model.sv
// system-side partner: drives the per-channel reference select pins
// assumes the bench says which channels are in use and which source it wants
`timescale 1ns/1ps
module plf_sys_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic [3:0] used,
  input wire logic [3:0] sel_req,
  // select pins toward the device
  output logic [3:0] ref_select_in
);
  // never floating, even before the first edge
  initial ref_select_in = 4'hF;
  // unused channels are held high
  always @(posedge clk) ref_select_in <= ~used | sel_req;
endmodule // plf_sys_model

// ### tb/pll_lock_flag_and_ref_select_tb.sv
// bench for plf_top: serial master, reference model and pin checks
// assumes the design files and plf_sys_model are compiled first
`timescale 1ns/1ps
`include "plf_defines.svh"
module pll_lock_flag_and_ref_select_tb;
  logic clk = 1'b0, resetn = 1'b0, sc = 1'b1, sd = 1'b1, ref_osc = 1'b0;
  logic [3:0] locked = 4'h0, in1 = 4'h0, pclk = 4'h0, used = 4'h0, sel_req = 4'h0;
  logic [3:0] sel, lol, lol_oe, stat, src, cpos, cneg, coe;
  logic sda_out, sda_oe;
  logic en [4], pol [4];
  logic [2:0] fmt [4];
  logic [7:0] v;
  int err_count = 0, check_count = 0, k, i;
  // open-drain data line with pull-up
  wire sda_w = sda_oe ? 1'b0 : sd;
  localparam logic [7:0] AW = {`PLF_I2C_ADDR, 1'b0};

  plf_sys_model u_sys (.clk(clk), .used(used), .sel_req(sel_req), .ref_select_in(sel));
  plf_top u_dut (.clk(clk), .resetn(resetn), .scl(sc), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .pll_locked(locked), .ref_select_in(sel), .input_clock_one(in1),
    .reference_oscillator(ref_osc), .pll_clk(pclk), .loss_of_lock_out(lol),
    .loss_of_lock_oe(lol_oe), .lock_status_bit(stat), .src_clk(src),
    .output_clock_pos(cpos), .output_clock_neg(cneg), .output_clock_oe(coe));

  always #12.5 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    // about 60k cycles, well above the expected run length
    #1500000;
    err_count++;
    print_verdict;
  end

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask

  // data moves only well after the clock fall so no false start or stop is seen
  task automatic ib(logic b, output logic r);
    tick(2); sd <= b; tick(6); sc <= 1'b1; tick(8); r = sda_w; sc <= 1'b0;
  endtask

  task automatic start;
    tick(2); sd <= 1'b1; tick(6); sc <= 1'b1; tick(8); sd <= 1'b0; tick(8); sc <= 1'b0;
  endtask

  task automatic stop;
    tick(2); sd <= 1'b0; tick(6); sc <= 1'b1; tick(8); sd <= 1'b1; tick(8);
  endtask

  task automatic wb(logic [7:0] d, logic ea);
    logic a;
    for (int j = 7; j >= 0; j--) ib(d[j], a);
    ib(1'b1, a);
    chk("ack", {7'h00, a}, {7'h00, ea});
  endtask

  task automatic wr(logic [7:0] p, logic [7:0] d);
    start; wb(AW, 1'b0); wb(p, 1'b0); wb(d, 1'b0); stop;
  endtask

  task automatic rd(logic [7:0] p, output logic [7:0] d);
    logic a;
    start; wb(AW, 1'b0); wb(p, 1'b0);
    start; wb(AW | 8'h01, 1'b0);
    for (int j = 0; j < 8; j++) begin
      ib(1'b1, a);
      d = {d[6:0], a};
    end
    ib(1'b1, a);
    stop;
  endtask

  task automatic cpins;
    logic [3:0] eo, eoe, es, ep, en_, ec;
    tick(8);
    for (int c = 0; c < 4; c++) begin
      eoe[c] = en[c];
      eo[c] = locked[c] ^ pol[c];
      es[c] = sel[c] ? ref_osc : in1[c];
      ec[c] = fmt[c] >= 3'h1 && fmt[c] <= 3'h4;
      ep[c] = ec[c] & pclk[c];
      en_[c] = (fmt[c] == 3'h4) ? pclk[c] : (ec[c] & ~pclk[c]);
    end
    chk("lol_oe", {4'h0, lol_oe}, {4'h0, eoe});
    chk("lol", {4'h0, lol}, {4'h0, eo});
    chk("status", {4'h0, stat}, {4'h0, locked});
    chk("src", {4'h0, src}, {4'h0, es});
    chk("pos", {4'h0, cpos}, {4'h0, ep});
    chk("neg", {4'h0, cneg}, {4'h0, en_});
    chk("coe", {4'h0, coe}, {4'h0, ec});
  endtask

  task automatic rst;
    resetn <= 1'b0;
    tick(16);
    chk("coe_rst", {4'h0, coe}, 8'h00);
    chk("lol_oe_rst", {4'h0, lol_oe}, 8'h00);
    resetn <= 1'b1;
    tick(4);
    for (int c = 0; c < 4; c++) begin
      en[c] = 1'b1; pol[c] = 1'b1; fmt[c] = 3'h0;
    end
    cpins;
    rd(`PLF_REG_CH0 + 8'h02, v);
    chk("cfg_rst", v, 8'h03);
  endtask

  initial begin
    void'($urandom(32'h7bfe));
    rst;
    // wrong address must not be acknowledged
    start; wb(8'hA0, 1'b1); stop;
    for (k = 0; k < 8; k++) begin
      locked <= 4'($urandom); in1 <= 4'($urandom); pclk <= 4'($urandom);
      ref_osc <= 1'($urandom); used <= 4'($urandom); sel_req <= 4'($urandom);
      // each channel differs so cross-talk shows up; all format codes reached
      for (i = 0; i < 4; i++) begin
        en[i] = 1'($urandom); pol[i] = 1'($urandom); fmt[i] = 3'(k + i);
        wr(8'(i), {3'h0, fmt[i], pol[i], en[i]});
      end
      cpins;
      rd(8'(k % 4), v);
      chk("cfg", v & 8'h1F, {3'h0, fmt[k % 4], pol[k % 4], en[k % 4]});
      rd(`PLF_REG_STATUS, v);
      chk("status_reg", v & 8'h0F, {4'h0, locked});
      if (k == 4) rst;
    end
    print_verdict;
  end
endmodule // pll_lock_flag_and_ref_select_tb
